// ### sep_defs.svh
// Constants of the serial EEPROM command port: timing, opcodes, frame sizes
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH
`define SEP_CLK_NS 10
`define SEP_SK_HALF_NS 250
`define SEP_DESELECT_MIN_NS 250
`define SEP_STATUS_WAIT_NS 250
`define SEP_POWERUP_READ_DELAY_MS 1
`define SEP_POWERUP_WRITE_DELAY_MS 1
`define SEP_PROG_PULSE_MS 5
`define SEP_OPC_READ 2'h2
`define SEP_OPC_WRITE 2'h1
`define SEP_OPC_CLEAR 2'h3
`define SEP_OPC_EXT 2'h0
`define SEP_EXT_UNLOCK 2'h3
`define SEP_EXT_LOCK 2'h0
`define SEP_EXT_CLEAR_ALL 2'h2
`define SEP_EXT_FILL_ALL 2'h1
`define SEP_FRAME_WIDE 13
`define SEP_FRAME_NARROW 14
`define SEP_DATA_WIDE 16
`define SEP_DATA_NARROW 8
`define SEP_MEM_BYTES 1024
`define SEP_LAST_BYTE 10'h3FF
`define SEP_ERASED_WORD 16'hFFFF
`endif

// ### sep_pkg.sv
// Types shared by both ends of the serial EEPROM command port
package sep_pkg;
  typedef enum logic [2:0] {
    SEP_CMD_READ,
    SEP_CMD_WRITE,
    SEP_CMD_CLEAR,
    SEP_CMD_UNLOCK,
    SEP_CMD_LOCK,
    SEP_CMD_CLEAR_ALL,
    SEP_CMD_FILL_ALL
  } sep_cmd_e;
  typedef struct packed {
    logic [5:0] len;
    logic [31:0] bits;
  } sep_frame_s;
endpackage

// ### sep_link_if.sv
// Pin-level link between host and serial EEPROM device
`timescale 1ns/10ps
interface sep_link_if;
  logic select;
  logic serial_clock;
  logic serial_in;
  logic wide_org;
  logic so_out;
  logic so_oe;
  logic so_line;
  // Floating data-out reads high, as through a pull-up
  assign so_line = so_oe ? so_out : 1'b1;
  modport dev (input select, input serial_clock, input serial_in, input wide_org, output so_out, output so_oe);
  modport host (output select, output serial_clock, output serial_in, output wide_org, input so_line);
endinterface

// ### sep_host.sv
// Host end of the serial EEPROM command port: frame sender, reader and status poller
`timescale 1ns/10ps
`include "sep_defs.svh"
module sep_host #(
  parameter int POWERUP_CYCLES = (`SEP_POWERUP_WRITE_DELAY_MS * 1000000 + `SEP_CLK_NS - 1) / `SEP_CLK_NS
) (
  input wire logic clk,
  input wire logic resetn,
  sep_link_if.host link,
  input wire logic cmd_valid,
  input wire sep_pkg::sep_cmd_e cmd_op,
  input wire logic [10:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic wide_org,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  import sep_pkg::*;
  localparam int HALF = (`SEP_SK_HALF_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS;
  localparam int DESEL = (`SEP_DESELECT_MIN_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS;
  localparam int POLL = (`SEP_STATUS_WAIT_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS;
  typedef enum logic [2:0] {HS_PWR, HS_IDLE, HS_SHIFT, HS_READ, HS_GAP, HS_POLL, HS_REL, HS_END} sep_hst_e;
  sep_hst_e state;
  logic [31:0] tc;
  logic [5:0] nb;
  logic [31:0] tx;
  logic [15:0] rx;
  logic is_read;
  logic poll;
  logic wide_q;
  logic [1:0] so_p;
  sep_frame_s next_frame;

  function automatic sep_frame_s frame(sep_cmd_e op, logic [10:0] a, logic [15:0] d, logic w);
    logic [1:0] opc;
    logic [1:0] ext;
    logic [10:0] af;
    logic [31:0] f;
    logic [5:0] n;
    logic has_data;
    sep_frame_s r;
    ext = `SEP_EXT_LOCK;
    opc = `SEP_OPC_EXT;
    has_data = (op == SEP_CMD_WRITE) || (op == SEP_CMD_FILL_ALL);
    case (op)
      SEP_CMD_READ: opc = `SEP_OPC_READ;
      SEP_CMD_WRITE: opc = `SEP_OPC_WRITE;
      SEP_CMD_CLEAR: opc = `SEP_OPC_CLEAR;
      SEP_CMD_UNLOCK: ext = `SEP_EXT_UNLOCK;
      SEP_CMD_CLEAR_ALL: ext = `SEP_EXT_CLEAR_ALL;
      SEP_CMD_FILL_ALL: ext = `SEP_EXT_FILL_ALL;
      default: ext = `SEP_EXT_LOCK;
    endcase
    // Ignored address MSB is always sent, held at zero in read, write and clear frames
    af = w ? {2'h0, a[8:0]} : {1'h0, a[9:0]};
    if (opc == `SEP_OPC_EXT) begin
      af = w ? {1'h0, ext, 8'h00} : {ext, 9'h000};
    end
    f = w ? {19'h0, 1'b1, opc, af[9:0]} : {18'h0, 1'b1, opc, af};
    n = w ? 6'(`SEP_FRAME_WIDE) : 6'(`SEP_FRAME_NARROW);
    if (has_data) begin
      f = w ? {f[15:0], d} : {f[23:0], d[7:0]};
      n = n + (w ? 6'(`SEP_DATA_WIDE) : 6'(`SEP_DATA_NARROW));
    end
    r.len = n;
    r.bits = f << (6'h20 - n);
    return r;
  endfunction

  assign next_frame = frame(cmd_op, cmd_addr, cmd_data, wide_org);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      so_p <= 2'h0;
    end else begin
      so_p <= {so_p[0], link.so_line};
    end
  end

  always_ff @(posedge clk) begin
    rsp_valid <= 1'b0;
    if (!resetn) begin
      state <= HS_PWR;
      tc <= 32'h0;
      nb <= 6'h00;
      tx <= 32'h0;
      rx <= 16'h0000;
      is_read <= 1'b0;
      poll <= 1'b0;
      wide_q <= 1'b1;
      cmd_ready <= 1'b0;
      rsp_data <= 16'h0000;
      link.select <= 1'b0;
      link.serial_clock <= 1'b0;
      link.serial_in <= 1'b0;
      link.wide_org <= 1'b1;
    end else begin
      case (state)
        HS_PWR: begin
          if (tc == 32'(POWERUP_CYCLES - 1)) begin
            tc <= 32'h0;
            cmd_ready <= 1'b1;
            state <= HS_IDLE;
          end else begin
            tc <= tc + 32'h1;
          end
        end
        HS_IDLE: begin
          link.wide_org <= wide_org;
          wide_q <= wide_org;
          if (cmd_valid) begin
            tx <= next_frame.bits;
            nb <= next_frame.len;
            is_read <= cmd_op == SEP_CMD_READ;
            poll <= cmd_op inside {SEP_CMD_WRITE, SEP_CMD_CLEAR, SEP_CMD_CLEAR_ALL, SEP_CMD_FILL_ALL};
            cmd_ready <= 1'b0;
            tc <= 32'h0;
            link.select <= 1'b1;
            state <= HS_SHIFT;
          end
        end
        HS_SHIFT, HS_READ, HS_REL: begin
          if (tc == 32'h0) begin
            link.serial_in <= (state == HS_REL) || (state == HS_SHIFT && tx[31]);
          end
          if (tc == 32'(HALF)) begin
            link.serial_clock <= 1'b1;
          end
          if (tc == 32'(2 * HALF - 1)) begin
            link.serial_clock <= 1'b0;
            tx <= {tx[30:0], 1'b0};
            rx <= {rx[14:0], so_p[1]};
            nb <= nb - 6'h01;
            tc <= 32'h0;
            if (nb == 6'h01) begin
              if (state == HS_SHIFT && is_read) begin
                nb <= wide_q ? 6'(`SEP_DATA_WIDE) : 6'(`SEP_DATA_NARROW);
                state <= HS_READ;
              end else begin
                // Select drops before the next clock rise
                link.select <= 1'b0;
                state <= HS_GAP;
                if (state == HS_READ) begin
                  rsp_data <= wide_q ? {rx[14:0], so_p[1]} : {8'h00, rx[6:0], so_p[1]};
                end
                if (state != HS_SHIFT) begin
                  poll <= 1'b0;
                end
              end
            end
          end else begin
            tc <= tc + 32'h1;
          end
        end
        HS_GAP: begin
          if (tc == 32'(DESEL - 1)) begin
            tc <= 32'h0;
            link.select <= poll;
            state <= poll ? HS_POLL : HS_END;
          end else begin
            tc <= tc + 32'h1;
          end
        end
        HS_POLL: begin
          if (tc == 32'(POLL - 1)) begin
            tc <= 32'h0;
            if (so_p[1]) begin
              nb <= 6'h01;
              state <= HS_REL;
            end
          end else begin
            tc <= tc + 32'h1;
          end
        end
        HS_END: begin
          rsp_valid <= 1'b1;
          cmd_ready <= 1'b1;
          state <= HS_IDLE;
        end
        default: state <= HS_IDLE;
      endcase
    end
  end
endmodule // sep_host

// ### sep_dev.sv
// Device end of the serial EEPROM command port: decoder, array and self-timed engine
`timescale 1ns/10ps
`include "sep_defs.svh"
// Summary of operation
// - Start bit, opcode, address, then data
// - Opcode 10 reads, 11 clears one word
// - Opcode 01 writes; 00 extended by MSBs
// - Frames 13 bits wide, 14 bits narrow
// - Input bits sampled on clock rising edge
// - Data-out floats unless reading or status
// - Status low while busy, high when ready
// - Dummy one releases status at falling edge
// - Read: dummy zero, then word MSB first
// - Sequential read advances, wraps to zero
// - Only first read word has dummy zero
// - Select fall after data starts cycle
// - Write clears location before storing automatically
// - Clear sets addressed word to all ones
// - Powers up locked; locked ignores writes
// - Unlock persists until lock or power-off
// - Reads work whether locked or unlocked
// - Clear-all sets whole array to ones
// - Fill-all writes word to every location
// - Clock rise before select fall aborts
// - Host waits 1 ms after power-up
// - Address MSB always sent, value ignored
// - Width pin high gives 16-bit words
module sep_dev #(
  parameter int PROG_CYCLES = (`SEP_PROG_PULSE_MS * 1000000) / `SEP_CLK_NS
) (
  input wire logic clk,
  input wire logic resetn,
  sep_link_if.dev link
);
  import sep_pkg::*;
  typedef enum logic [2:0] {DS_IDLE, DS_CMD, DS_DATA, DS_ARM, DS_READ, DS_HOLD} sep_dst_e;
  sep_dst_e state;
  logic [2:0] sel_p;
  logic [2:0] sck_p;
  logic [1:0] din_p;
  logic [1:0] org_p;
  logic sel;
  logic sel_fall;
  logic sck_rise;
  logic sck_fall;
  logic din;
  logic wide;
  logic [7:0] mem [0:`SEP_MEM_BYTES-1];
  logic [4:0] bitcnt;
  logic [11:0] cmd;
  logic [12:0] nxt;
  logic [1:0] opc;
  logic [1:0] ext;
  logic [9:0] a;
  logic [4:0] clen;
  logic [4:0] dlen;
  logic [15:0] dat;
  logic [9:0] addr;
  logic [15:0] rdw;
  logic unlocked;
  logic stat_mode;
  logic rel_pend;
  logic go;
  logic [9:0] go_lo;
  logic [9:0] go_hi;
  logic [15:0] go_dat;
  logic busy;
  logic [31:0] busy_cnt;
  logic wr_run;
  logic [9:0] wr_ptr;
  logic [9:0] wr_end;
  logic [15:0] wr_dat;
  logic [7:0] wr_byte;

  // Next word index, wrapping at the end of the space
  function automatic logic [9:0] bump(logic [9:0] x, logic w);
    return w ? {1'b0, x[8:0] + 9'h001} : x + 10'h001;
  endfunction

  // Word at an index, left-aligned for the narrow width
  function automatic logic [15:0] word_at(logic [9:0] x, logic w);
    return w ? {mem[{x[8:0], 1'b0}], mem[{x[8:0], 1'b1}]} : {mem[x], 8'h00};
  endfunction

  // Pins cross into the clock domain
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_p <= 3'h0;
      sck_p <= 3'h0;
      din_p <= 2'h0;
      org_p <= 2'h3;
    end else begin
      sel_p <= {sel_p[1:0], link.select};
      sck_p <= {sck_p[1:0], link.serial_clock};
      din_p <= {din_p[0], link.serial_in};
      org_p <= {org_p[0], link.wide_org};
    end
  end

  assign sel = sel_p[1];
  assign sel_fall = sel_p[2] & ~sel_p[1];
  assign sck_rise = sck_p[1] & ~sck_p[2];
  assign sck_fall = sck_p[2] & ~sck_p[1];
  assign din = din_p[1];
  assign wide = org_p[1];

  // Frame decode on the bit being shifted in
  assign nxt = {cmd, din};
  assign clen = wide ? 5'(`SEP_FRAME_WIDE - 2) : 5'(`SEP_FRAME_NARROW - 2);
  assign dlen = wide ? 5'(`SEP_DATA_WIDE) : 5'(`SEP_DATA_NARROW);
  assign opc = wide ? nxt[11:10] : nxt[12:11];
  assign ext = wide ? nxt[9:8] : nxt[10:9];
  assign a = wide ? {1'b0, nxt[8:0]} : nxt[9:0];

  always_ff @(posedge clk) begin
    go <= 1'b0;
    if (!resetn) begin
      state <= DS_IDLE;
      bitcnt <= 5'h00;
      cmd <= 12'h000;
      dat <= 16'h0000;
      addr <= 10'h000;
      rdw <= 16'h0000;
      unlocked <= 1'b0;
      stat_mode <= 1'b0;
      rel_pend <= 1'b0;
      go_lo <= 10'h000;
      go_hi <= 10'h000;
      go_dat <= 16'h0000;
      link.so_out <= 1'b0;
      link.so_oe <= 1'b0;
    end else if (!sel) begin
      state <= DS_IDLE;
      rel_pend <= 1'b0;
      link.so_oe <= 1'b0;
      if (sel_fall && state == DS_ARM) begin
        stat_mode <= 1'b1;
        go <= unlocked;
      end
    end else begin
      if (sck_fall && rel_pend) begin
        link.so_oe <= 1'b0;
        rel_pend <= 1'b0;
      end
      case (state)
        DS_IDLE: begin
          if (stat_mode && !rel_pend) begin
            link.so_oe <= 1'b1;
            link.so_out <= ~busy;
          end
          if (sck_rise && din) begin
            rel_pend <= stat_mode;
            stat_mode <= 1'b0;
            if (!busy) begin
              bitcnt <= 5'h00;
              state <= DS_CMD;
            end
          end
        end
        DS_CMD: begin
          if (sck_rise) begin
            cmd <= nxt[11:0];
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == clen) begin
              bitcnt <= 5'h00;
              go_lo <= wide ? {a[8:0], 1'b0} : a;
              go_hi <= wide ? {a[8:0], 1'b1} : a;
              case (opc)
                `SEP_OPC_READ: begin
                  addr <= a;
                  rdw <= word_at(a, wide);
                  link.so_oe <= 1'b1;
                  link.so_out <= 1'b0;
                  state <= DS_READ;
                end
                `SEP_OPC_WRITE: state <= DS_DATA;
                `SEP_OPC_CLEAR: begin
                  go_dat <= `SEP_ERASED_WORD;
                  state <= DS_ARM;
                end
                default: begin
                  case (ext)
                    `SEP_EXT_UNLOCK: begin
                      unlocked <= 1'b1;
                      state <= DS_HOLD;
                    end
                    `SEP_EXT_LOCK: begin
                      unlocked <= 1'b0;
                      state <= DS_HOLD;
                    end
                    `SEP_EXT_CLEAR_ALL: begin
                      go_lo <= 10'h000;
                      go_hi <= `SEP_LAST_BYTE;
                      go_dat <= `SEP_ERASED_WORD;
                      state <= DS_ARM;
                    end
                    default: begin
                      go_lo <= 10'h000;
                      go_hi <= `SEP_LAST_BYTE;
                      state <= DS_DATA;
                    end
                  endcase
                end
              endcase
            end
          end
        end
        DS_DATA: begin
          if (sck_rise) begin
            dat <= {dat[14:0], din};
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == dlen - 5'h01) begin
              go_dat <= wide ? {dat[14:0], din} : {8'h00, dat[6:0], din};
              state <= DS_ARM;
            end
          end
        end
        DS_ARM: begin
          if (sck_rise) begin
            state <= DS_HOLD;
          end
        end
        DS_READ: begin
          if (sck_rise) begin
            link.so_out <= rdw[15];
            if (bitcnt == dlen - 5'h01) begin
              bitcnt <= 5'h00;
              addr <= bump(addr, wide);
              rdw <= word_at(bump(addr, wide), wide);
            end else begin
              bitcnt <= bitcnt + 5'h01;
              rdw <= {rdw[14:0], 1'b0};
            end
          end
        end
        DS_HOLD: state <= DS_HOLD;
        default: state <= DS_IDLE;
      endcase
    end
  end

  // Self-timed cycle: busy window and byte sweep
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy <= 1'b0;
      busy_cnt <= 32'h0;
      wr_run <= 1'b0;
      wr_ptr <= 10'h000;
      wr_end <= 10'h000;
      wr_dat <= 16'h0000;
    end else if (go) begin
      busy <= 1'b1;
      busy_cnt <= 32'(PROG_CYCLES - 1);
      wr_run <= 1'b1;
      wr_ptr <= go_lo;
      wr_end <= go_hi;
      wr_dat <= go_dat;
    end else begin
      if (busy) begin
        if (busy_cnt == 32'h0) begin
          busy <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt - 32'h1;
        end
      end
      if (wr_run) begin
        if (wr_ptr == wr_end) begin
          wr_run <= 1'b0;
        end else begin
          wr_ptr <= wr_ptr + 10'h001;
        end
      end
    end
  end

  assign wr_byte = (wide && !wr_ptr[0]) ? wr_dat[15:8] : wr_dat[7:0];

  // Plain overwrite gives clear-then-store in one step
  always_ff @(posedge clk) begin
    if (wr_run) begin
      mem[wr_ptr] <= wr_byte;
    end
  end
endmodule // sep_dev

// ### sep_link_assertions.sv
// Pin-level checker for the serial EEPROM command link
`timescale 1ns/10ps
module sep_link_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic wide_org,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic so_line
);
  logic sk_q;
  logic sk_rise;
  logic [5:0] rises;
  logic [7:0] low_cnt;
  assign sk_rise = serial_clock && !sk_q;
  always_ff @(posedge clk) begin
    if (!resetn) sk_q <= 1'b0;
    else sk_q <= serial_clock;
  end
  // Clock rises within the current selection
  always_ff @(posedge clk) begin
    if (!resetn || !select) rises <= 6'h00;
    else if (sk_rise && rises != 6'h3F) rises <= rises + 6'h01;
  end
  // Reset time counts as deselected
  always_ff @(posedge clk) begin
    if (!resetn) low_cnt <= 8'hFF;
    else if (select) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_si_stable_at_rise; $rose(serial_clock) |-> $stable(serial_in)[*8]; endproperty
  a_si_stable_at_rise: assert property (p_si_stable_at_rise) else $error("data-in moved near clock rise");
  property p_sk_low_held; $fell(serial_clock) |-> !serial_clock[*8]; endproperty
  a_sk_low_held: assert property (p_sk_low_held) else $error("serial clock low phase too short");
  property p_start_bit; sk_rise && select && rises == 6'h00 |-> serial_in; endproperty
  a_start_bit: assert property (p_start_bit) else $error("frame without leading one");
  property p_frame_len;
    $fell(select) |-> (wide_org ? (rises == 6'h01 || rises == 6'h0D || rises == 6'h1D)
                                : (rises == 6'h01 || rises == 6'h0E || rises == 6'h16));
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_deselect_min; $rose(select) |-> low_cnt >= 8'h19; endproperty
  a_deselect_min: assert property (p_deselect_min) else $error("deselect shorter than minimum");
  property p_select_fall_sk_low; $fell(select) |-> !serial_clock; endproperty
  a_select_fall_sk_low: assert property (p_select_fall_sk_low) else $error("select fell with clock high");
  property p_oe_off_deselected; !select[*6] |-> !so_oe && so_line; endproperty
  a_oe_off_deselected: assert property (p_oe_off_deselected) else $error("data-out driven while deselected");
  property p_org_stable; select && $past(select) |-> $stable(wide_org); endproperty
  a_org_stable: assert property (p_org_stable) else $error("width select moved in frame");
  property p_sk_idle; !select[*2] |-> !serial_clock; endproperty
  a_sk_idle: assert property (p_sk_idle) else $error("serial clock runs outside frame");
  c_read_wide: cover property ($fell(select) && rises == 6'h1D);
  c_busy_status: cover property (select && so_oe && !so_out);
  c_narrow_frame: cover property ($fell(select) && rises == 6'h16);
endmodule // sep_link_assertions

// ### test_serial_eeprom_command_port.sv
// Self-checking bench: host and device ends joined over the link
`timescale 1ns/10ps
module test_serial_eeprom_command_port;
  import sep_pkg::*;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  sep_cmd_e cmd_op = SEP_CMD_READ;
  logic [10:0] cmd_addr = 11'h000;
  logic [15:0] cmd_data = 16'h0000;
  logic wide_org = 1'b1;
  logic cmd_ready;
  logic rsp_valid;
  logic [15:0] rsp_data;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  sep_link_if lnk();
  sep_host #(.POWERUP_CYCLES(10)) u_sep_host (.clk(clk), .resetn(resetn), .link(lnk), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .wide_org(wide_org), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  sep_dev #(.PROG_CYCLES(2000)) u_sep_dev (.clk(clk), .resetn(resetn), .link(lnk));
  sep_link_assertions u_sep_link_assertions (.clk(clk), .resetn(resetn), .select(lnk.select),
    .serial_clock(lnk.serial_clock), .serial_in(lnk.serial_in), .wide_org(lnk.wide_org), .so_out(lnk.so_out),
    .so_oe(lnk.so_oe), .so_line(lnk.so_line));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic results();
    $display("counts tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Entered and left just after a rising edge
  task automatic do_cmd(input sep_cmd_e op, input logic [10:0] addr, input logic [15:0] data);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 8000) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmd_op = op;
    cmd_addr = addr;
    cmd_data = data;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 8000) begin
      fails++;
      $display("mismatch response expected pulse seen none");
    end
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [10:0] addr, input logic [15:0] exp);
    do_cmd(SEP_CMD_READ, addr, 16'h0000);
    chk16("read word", exp, rsp_data);
  endtask
  task automatic t_lock();
    do_cmd(SEP_CMD_UNLOCK, 11'h000, 16'h0000);
    do_cmd(SEP_CMD_CLEAR_ALL, 11'h000, 16'h0000);
    rd(11'h000, 16'hFFFF);
    rd(11'h1FF, 16'hFFFF);
    do_cmd(SEP_CMD_LOCK, 11'h000, 16'h0000);
    do_cmd(SEP_CMD_WRITE, 11'h003, 16'h1234);
    rd(11'h003, 16'hFFFF);
    $display("test t_lock done");
  endtask
  task automatic t_write_clear();
    do_cmd(SEP_CMD_UNLOCK, 11'h000, 16'h0000);
    do_cmd(SEP_CMD_WRITE, 11'h003, 16'hA5C3);
    rd(11'h003, 16'hA5C3);
    do_cmd(SEP_CMD_WRITE, 11'h1FF, 16'h0F0F);
    rd(11'h1FF, 16'h0F0F);
    do_cmd(SEP_CMD_CLEAR, 11'h003, 16'h0000);
    rd(11'h003, 16'hFFFF);
    rd(11'h1FF, 16'h0F0F);
    $display("test t_write_clear done");
  endtask
  task automatic t_fill();
    do_cmd(SEP_CMD_FILL_ALL, 11'h000, 16'h5AA5);
    rd(11'h000, 16'h5AA5);
    rd(11'h12C, 16'h5AA5);
    rd(11'h1FF, 16'h5AA5);
    $display("test t_fill done");
  endtask
  task automatic t_narrow();
    wide_org = 1'b0;
    do_cmd(SEP_CMD_WRITE, 11'h3FF, 16'h00C3);
    rd(11'h3FF, 16'h00C3);
    rd(11'h000, 16'h005A);
    rd(11'h001, 16'h00A5);
    do_cmd(SEP_CMD_LOCK, 11'h000, 16'h0000);
    do_cmd(SEP_CMD_CLEAR, 11'h001, 16'h0000);
    rd(11'h001, 16'h00A5);
    wide_org = 1'b1;
    rd(11'h1FF, 16'h5AC3);
    $display("test t_narrow done");
  endtask
  task automatic t_powerup();
    do_cmd(SEP_CMD_UNLOCK, 11'h000, 16'h0000);
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    do_cmd(SEP_CMD_WRITE, 11'h000, 16'h0000);
    rd(11'h000, 16'h5AA5);
    $display("test t_powerup done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_lock();
    t_write_clear();
    t_fill();
    t_narrow();
    t_powerup();
    results();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      $display("mismatch run length expected below %0d seen %0d", LIMIT, cyc);
      results();
    end
  end
endmodule // test_serial_eeprom_command_port
